// file: logic/frs_pkg.sv
package frs_pkg;

	// Termination codes
	localparam logic [1:0] TERM_NORMAL   = 2'h0;
	localparam logic [1:0] TERM_ABNORMAL = 2'h1;
	localparam logic [1:0] TERM_INVALID  = 2'h2;
	localparam logic [1:0] TERM_POLLING  = 2'h3;

	// Interface mode field values
	localparam logic [1:0] MODE_FIRST  = 2'h0;
	localparam logic [1:0] MODE_SECOND = 2'h1;
	localparam logic [1:0] MODE_THIRD  = 2'h2;
	localparam int         MODE_LSB    = 2;

	// Digital output and rate-select register bit positions
	localparam int DOR_RESET_N_BIT = 2;
	localparam int DOR_DMA_EN_BIT  = 3;
	localparam int DSR_RESET_BIT   = 7;

	// Recalibrate step limit
	localparam logic [6:0] RECAL_STEP_LIMIT = 7'h50;

	// Bad track identifier value
	localparam logic [7:0] BAD_TRACK_ID = 8'hff;

	// Reset values
	localparam logic [7:0] DOR_RESET_VAL = 8'h00;
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [2:0] RES_COUNT_RST = 3'h0;

	// Result phase states
	typedef enum logic [1:0] {
		FRS_IDLE   = 2'b00,
		FRS_RESULT = 2'b01
	} frs_state_t;

endpackage

// file: logic/frs_core.sv
`timescale 1ns/100ps
// Functional notes
// - Status zero bits 7:6 hold termination code of the finished command.
// - Status zero bit 5 flags completed seek, relative seek or recalibrate.
// - Status zero bit 4: no track zero after 80 steps, or outward overrun.
// - Status zero: head in bit 2, drive in bits 1:0, bit 3 zero.
// - Status one bit 7: access past last sector, or no terminal count.
// - Status one bit 5: CRC error in id or data field; bits 6,3 zero.
// - Status one bit 4: service too late, overrun or underrun.
// - Status one bit 2: sector not found, id unreadable, sequence lost.
// - Status one bit 1: protect input high during write or format.
// - Status one bit 0: no id mark after two index pulses, or no data mark.
// - Status two bit 6: data mark type opposite to the read command.
// - Status two bit 5: data field CRC error; bits 7,3,2 zero.
// - Status two bit 4: id track differs from internal track.
// - Status two bit 1: id track mismatches and equals ff.
// - Status two bit 0: no data or deleted data mark detected.
// - Status three mirrors protect, track zero, head, drive pins; 5,3 one.
// - Pin, output-register and rate-select resets; any reset leaves power down.
// - Pin reset ends operations, clears registers but specify, sets reset bit.
// - Leaving reset clears configure settings and starts drive polling.
// - Software resets clear core; rate-select self-clears; output bit sticks, wins.
// - Mode from configuration bits 3:2: first, second or third mode.
// - First mode: output DMA bit gates interrupt and DMA; density active high.
// - Second mode: DMA bit ignored, always enabled; density active low.
// - Third mode: DMA bit gates interrupt and DMA; density active low.
module frs_core
	import frs_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	// Host register access
	input  wire logic       dor_wr_i,
	input  wire logic       dsr_wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       data_rd_i,
	input  wire logic [7:0] device_config_reg_i,
	// Phase sequencer status conditions
	input  wire logic       cmd_done_i,
	input  wire logic [1:0] termination_code_i,
	input  wire logic [2:0] result_count_i,
	input  wire logic       is_write_cmd_i,
	input  wire logic       is_read_deleted_i,
	input  wire logic       positioning_done_i,
	input  wire logic       recal_step_i,
	input  wire logic       recal_active_i,
	input  wire logic       rel_seek_outward_i,
	input  wire logic       past_last_sector_i,
	input  wire logic       no_tc_at_end_i,
	input  wire logic       id_crc_err_i,
	input  wire logic       data_crc_err_i,
	input  wire logic       service_late_i,
	input  wire logic       sector_missing_i,
	input  wire logic       index_seen_i,
	input  wire logic       id_mark_seen_i,
	input  wire logic       data_mark_missing_i,
	input  wire logic       deleted_mark_seen_i,
	input  wire logic       normal_mark_seen_i,
	input  wire logic       id_track_valid_i,
	input  wire logic [7:0] id_track_i,
	input  wire logic [7:0] internal_track_i,
	input  wire logic       head_addr_i,
	input  wire logic [1:0] drive_sel_i,
	input  wire logic       density_high_i,
	// Drive pins
	input  wire logic       protect_input_i,
	input  wire logic       track_zero_input_i,
	input  wire logic       side_select_output_i,
	input  wire logic [1:0] drive_select_outputs_i,
	// Outputs
	output logic [7:0]      data_o,
	output logic            core_reset_o,
	output logic            config_clear_o,
	output logic            polling_start_o,
	output logic            power_down_exit_o,
	output logic            irq_dma_enable_o,
	output logic            density_select_output_o,
	output logic [7:0]      digital_output_reg_o
);

	frs_state_t  state;
	logic [7:0]  digital_output_reg;
	logic        dsr_reset;
	logic        core_reset_q;
	logic [7:0]  result_status_zero;
	logic [7:0]  result_status_one;
	logic [7:0]  result_status_two;
	logic [6:0]  step_count;
	logic [1:0]  index_count;
	logic [2:0]  res_count;
	logic [2:0]  res_index;
	logic        prot_s1, prot_s2, trk_s1, trk_s2;
	logic        in_reset;
	logic [1:0]  mode;

	assign mode     = device_config_reg_i[MODE_LSB +: 2];
	// Output-register reset wins over rate-select reset
	// Reset precedence
	assign in_reset = ~digital_output_reg[DOR_RESET_N_BIT] | dsr_reset;

	// Pins cross in from the drive cable
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prot_s1 <= 1'b0;
			prot_s2 <= 1'b0;
			trk_s1  <= 1'b0;
			trk_s2  <= 1'b0;
		end else begin
			prot_s1 <= protect_input_i;
			prot_s2 <= prot_s1;
			trk_s1  <= track_zero_input_i;
			trk_s2  <= trk_s1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			digital_output_reg <= DOR_RESET_VAL;
		end else if (dor_wr_i) begin
			digital_output_reg <= wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dsr_reset <= 1'b0;
		end else begin
			dsr_reset <= dsr_wr_i & wdata_i[DSR_RESET_BIT];
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			core_reset_q      <= 1'b1;
			core_reset_o      <= 1'b1;
			config_clear_o    <= 1'b0;
			polling_start_o   <= 1'b0;
			power_down_exit_o <= 1'b1;
		end else begin
			core_reset_q      <= in_reset;
			core_reset_o      <= in_reset;
			power_down_exit_o <= in_reset;
			config_clear_o    <= core_reset_q & ~in_reset;
			polling_start_o   <= core_reset_q & ~in_reset;
		end
	end

	// Counts recalibrate steps and index pulses of the current command
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_count  <= 7'h00;
			index_count <= 2'h0;
		end else if (in_reset || cmd_done_i) begin
			step_count  <= 7'h00;
			index_count <= 2'h0;
		end else begin
			if (recal_step_i && step_count != RECAL_STEP_LIMIT)
				step_count <= step_count + 7'h01;
			if (id_mark_seen_i)
				index_count <= 2'h0;
			else if (index_seen_i && index_count != 2'h2)
				index_count <= index_count + 2'h1;
		end
	end

	// Status zero
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result_status_zero <= STATUS_RESET;
		end else if (in_reset) begin
			result_status_zero <= STATUS_RESET;
		end else if (cmd_done_i) begin
			result_status_zero[7:6] <= termination_code_i;
			result_status_zero[5]   <= positioning_done_i;
			result_status_zero[4]   <= (recal_active_i && step_count == RECAL_STEP_LIMIT
				&& !trk_s2) || rel_seek_outward_i;
			result_status_zero[3]   <= 1'b0;
			result_status_zero[2]   <= head_addr_i;
			result_status_zero[1:0] <= drive_sel_i;
		end
	end

	// Error flags are sticky within a command; set wins over the clear on the last result byte read
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result_status_one <= STATUS_RESET;
			result_status_two <= STATUS_RESET;
		end else if (in_reset) begin
			result_status_one <= STATUS_RESET;
			result_status_two <= STATUS_RESET;
		end else begin
			if (state == FRS_RESULT && data_rd_i && res_index == res_count - 3'h1) begin
				result_status_one <= STATUS_RESET;
				result_status_two <= STATUS_RESET;
			end
			if (past_last_sector_i || (cmd_done_i && no_tc_at_end_i))
				result_status_one[7] <= 1'b1;
			if (id_crc_err_i || data_crc_err_i)
				result_status_one[5] <= 1'b1;
			if (service_late_i)
				result_status_one[4] <= 1'b1;
			if (sector_missing_i)
				result_status_one[2] <= 1'b1;
			if (is_write_cmd_i && prot_s2)
				result_status_one[1] <= 1'b1;
			if (index_count == 2'h2 || data_mark_missing_i)
				result_status_one[0] <= 1'b1;
			if ((!is_read_deleted_i && deleted_mark_seen_i) ||
				(is_read_deleted_i && normal_mark_seen_i))
				result_status_two[6] <= 1'b1;
			if (data_crc_err_i)
				result_status_two[5] <= 1'b1;
			if (id_track_valid_i && id_track_i != internal_track_i)
				result_status_two[4] <= 1'b1;
			if (id_track_valid_i && id_track_i != internal_track_i &&
				id_track_i == BAD_TRACK_ID)
				result_status_two[1] <= 1'b1;
			if (data_mark_missing_i)
				result_status_two[0] <= 1'b1;
			result_status_one[6] <= 1'b0;
			result_status_one[3] <= 1'b0;
			result_status_two[7] <= 1'b0;
			result_status_two[3] <= 1'b0;
			result_status_two[2] <= 1'b0;
		end
	end

	// Result phase byte sequencing
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state     <= FRS_IDLE;
			res_index <= RES_COUNT_RST;
			res_count <= RES_COUNT_RST;
		end else if (in_reset) begin
			state     <= FRS_IDLE;
			res_index <= RES_COUNT_RST;
		end else begin
			unique case (state)
				FRS_IDLE: begin
					if (cmd_done_i && result_count_i != 3'h0) begin
						state     <= FRS_RESULT;
						res_count <= result_count_i;
						res_index <= RES_COUNT_RST;
					end
				end
				FRS_RESULT: begin
					if (data_rd_i) begin
						if (res_index == res_count - 3'h1)
							state <= FRS_IDLE;
						else
							res_index <= res_index + 3'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_o <= STATUS_RESET;
		end else begin
			unique case (res_index[1:0])
				2'h0: data_o <= result_status_zero;
				2'h1: data_o <= result_status_one;
				2'h2: data_o <= result_status_two;
				2'h3: data_o <= {1'b0, prot_s2, 1'b1, trk_s2, 1'b1, side_select_output_i,
					drive_select_outputs_i};
			endcase
		end
	end

	// Mode dependent gating and polarity
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_dma_enable_o        <= 1'b0;
			density_select_output_o <= 1'b1;
			digital_output_reg_o    <= DOR_RESET_VAL;
		end else begin
			digital_output_reg_o <= digital_output_reg;
			unique case (mode)
				MODE_SECOND: begin
					irq_dma_enable_o        <= 1'b1;
					density_select_output_o <= ~density_high_i;
				end
				MODE_THIRD: begin
					irq_dma_enable_o        <= digital_output_reg[DOR_DMA_EN_BIT];
					density_select_output_o <= ~density_high_i;
				end
				// Gated, active high; unused code treated alike
				default: begin
					irq_dma_enable_o        <= digital_output_reg[DOR_DMA_EN_BIT];
					density_select_output_o <= density_high_i;
				end
			endcase
		end
	end

endmodule

// file: testbench/frs_core_monitor.sv
`timescale 1ns/100ps
module frs_core_monitor
	import frs_pkg::*;
(
	// Clock and reset
	input wire logic       core_clk_i,
	input wire logic       rstn_i,
	// Host and sequencer inputs
	input wire logic       dor_wr_i,
	input wire logic       dsr_wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       data_rd_i,
	input wire logic [7:0] device_config_reg_i,
	input wire logic       density_high_i,
	input wire logic       cmd_done_i,
	input wire logic [1:0] termination_code_i,
	input wire logic [2:0] result_count_i,
	input wire logic       head_addr_i,
	input wire logic [1:0] drive_sel_i,
	// Outputs
	input wire logic [7:0] data_o,
	input wire logic       core_reset_o,
	input wire logic       config_clear_o,
	input wire logic       polling_start_o,
	input wire logic       power_down_exit_o,
	input wire logic       irq_dma_enable_o,
	input wire logic       density_select_output_o,
	input wire logic [7:0] digital_output_reg_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	logic [1:0] mode;
	assign mode = device_config_reg_i[3:2];
	sequence done_quiet;
		cmd_done_i && result_count_i != 3'h0 && !core_reset_o && !data_rd_i ##1 !data_rd_i;
	endsequence
	AST_TERM_CODE: assert property (
		done_quiet |=> ##1 data_o[7:6] == $past(termination_code_i, 3)) else $error("bad code");
	AST_HEAD_DRIVE: assert property (
		done_quiet |=> ##1 data_o[3:0] == {1'b0, $past(head_addr_i, 3), $past(drive_sel_i, 3)})
		else $error("bad head or drive");
	AST_DOR_STICKY: assert property (
		!digital_output_reg_o[DOR_RESET_N_BIT] && !dor_wr_i && !$past(dor_wr_i)
		|=> !digital_output_reg_o[DOR_RESET_N_BIT]) else $error("reset bit lost");
	AST_DOR_WINS: assert property (
		!digital_output_reg_o[DOR_RESET_N_BIT] |-> ##[0:2] core_reset_o) else $error("not in reset");
	AST_EXIT_DELAY: assert property (
		dor_wr_i && wdata_i[DOR_RESET_N_BIT] && !digital_output_reg_o[DOR_RESET_N_BIT]
		|-> ##2 !core_reset_o) else $error("reset exit late");
	AST_EXIT_PULSES: assert property (
		$fell(core_reset_o) |-> ##[0:1] (config_clear_o && polling_start_o)
		##1 !(config_clear_o || polling_start_o)) else $error("exit pulses wrong");
	AST_PWR_EXIT: assert property (
		power_down_exit_o == core_reset_o) else $error("power down exit wrong");
	AST_DSR_SELF: assert property (
		dsr_wr_i && wdata_i[DSR_RESET_BIT] && digital_output_reg_o[DOR_RESET_N_BIT] && !dor_wr_i
		|-> ##[1:2] core_reset_o ##[1:2] !core_reset_o) else $error("rate reset stuck");
	AST_IRQ_GATE: assert property (
		(!core_reset_o && $stable(device_config_reg_i) && $stable(digital_output_reg_o)) [*2]
		|-> irq_dma_enable_o == (mode == MODE_SECOND || digital_output_reg_o[DOR_DMA_EN_BIT]))
		else $error("gate wrong");
	AST_DENSITY: assert property (
		($stable(device_config_reg_i) && $stable(density_high_i)) [*2]
		|-> density_select_output_o == (density_high_i ^ (mode == MODE_SECOND || mode == MODE_THIRD)))
		else $error("density wrong");
	cover property ($fell(core_reset_o));
	cover property (cmd_done_i && result_count_i == 3'h4);
	cover property (dsr_wr_i && wdata_i[DSR_RESET_BIT]);
endmodule

bind frs_core frs_core_monitor i_mon (.*);

// file: testbench/frs_drive_model.sv
`timescale 1ns/100ps
module frs_drive_model (
	// Clock and controls
	input  wire logic       core_clk_i,
	input  wire logic       load_i,
	input  wire logic [7:0] cyl_i,
	input  wire logic       step_i,
	input  wire logic       protect_i,
	// Drive pins
	output logic            protect_input_o,
	output logic            track_zero_input_o
);
	logic [7:0] cyl = 8'h00;
	// Head steps out one track a pulse and stops at track zero
	always @(posedge core_clk_i) begin
		if (load_i) begin
			cyl <= cyl_i;
		end else if (step_i && cyl != 8'h00) begin
			cyl <= cyl - 8'h01;
		end
	end
	// Sensors lag the edge, so the pins are truly asynchronous
	assign #3 track_zero_input_o = (cyl == 8'h00);
	assign #3 protect_input_o = protect_i;
endmodule

// file: testbench/frs_core_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module frs_core_test
	import frs_pkg::*;
;
	logic       core_clk_i, rstn_i, dor_wr_i, dsr_wr_i, data_rd_i, cmd_done_i, look, load, wp;
	logic [7:0] wdata_i, device_config_reg_i, id_track_i, internal_track_i, data_o, cyl, o, e;
	logic [7:0] digital_output_reg_o, exp_q[$], st[4];
	logic [1:0] termination_code_i, drive_sel_i, drive_select_outputs_i;
	logic [2:0] result_count_i;
	logic [9:0] ev;
	logic       is_write_cmd_i, is_read_deleted_i, positioning_done_i, recal_step_i;
	logic       recal_active_i, rel_seek_outward_i, past_last_sector_i, no_tc_at_end_i;
	logic       id_crc_err_i, data_crc_err_i, service_late_i, sector_missing_i, index_seen_i;
	logic       id_mark_seen_i, data_mark_missing_i, deleted_mark_seen_i, normal_mark_seen_i;
	logic       id_track_valid_i, head_addr_i, density_high_i, protect_input_i;
	logic       track_zero_input_i, side_select_output_i, core_reset_o, config_clear_o;
	logic       polling_start_o, power_down_exit_o, irq_dma_enable_o, density_select_output_o;
	logic [31:0] seed;
	int         sel_q[$], num_errors, samples_checked;
	assign {past_last_sector_i, id_crc_err_i, data_crc_err_i, service_late_i, sector_missing_i,
		data_mark_missing_i, deleted_mark_seen_i, normal_mark_seen_i, id_track_valid_i,
		index_seen_i} = ev;
	frs_drive_model i_drive (
		.core_clk_i         (core_clk_i),
		.load_i             (load),
		.cyl_i              (cyl),
		.step_i             (recal_step_i),
		.protect_i          (wp),
		.protect_input_o    (protect_input_i),
		.track_zero_input_o (track_zero_input_i)
	);
	frs_core i_dut (.*);
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] seen(input int s);
		case (s)
			0: return data_o;
			1: return {4'h0, core_reset_o, power_down_exit_o, irq_dma_enable_o, density_select_output_o};
			2: return digital_output_reg_o;
			default: return {6'h0, core_reset_o, power_down_exit_o};
		endcase
	endfunction
	always @(posedge core_clk_i) begin
		if (look || data_rd_i) begin
			o = seen(sel_q.pop_front());
			e = exp_q.pop_front();
			`CHK(o, e)
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask
	task automatic note(input int s, input logic [7:0] v);
		sel_q.push_back(s);
		exp_q.push_back(v);
		look = 1'b1;
		@(posedge core_clk_i);
		#1 look = 1'b0;
		#1;
	endtask
	task automatic wr(input logic d, input logic [7:0] v);
		{dor_wr_i, dsr_wr_i} = {d, !d};
		wdata_i = v;
		tick(1);
		{dor_wr_i, dsr_wr_i} = 2'b00;
		tick(1);
	endtask
	task automatic hard_reset();
		rstn_i = 1'b0;
		tick(4);
		rstn_i = 1'b1;
		note(1, 8'h0d);
		note(2, 8'h00);
	endtask
	task automatic run_cmd(input logic [31:0] r, input logic [7:0] c, input int steps);
		logic wc;
		{wp, side_select_output_i, drive_select_outputs_i} = {r[29], r[25], r[27:26]};
		{is_write_cmd_i, is_read_deleted_i, internal_track_i} = {r[30], r[19], r[15:8]};
		id_track_i = r[16] ? 8'hff : (r[17] ? r[15:8] : ~r[15:8]);
		{load, cyl, id_mark_seen_i, recal_active_i} = {1'b1, c, 1'b1, steps > 0};
		tick(1);
		{load, id_mark_seen_i} = 2'b00;
		repeat (steps) begin
			recal_step_i = 1'b1;
			tick(1);
			recal_step_i = 1'b0;
			tick(1);
		end
		ev = {r[6:0], r[20], r[7], 1'b1};
		tick(1);
		ev = '0;
		tick(1);
		// second index pulse without a mark
		if (r[18]) begin
			ev = 10'h1;
			tick(1);
			ev = '0;
		end
		{termination_code_i, positioning_done_i, head_addr_i} = {r[23:22], r[24], r[25]};
		{drive_sel_i, rel_seek_outward_i, no_tc_at_end_i} = {r[27:26], r[28], r[21]};
		{result_count_i, cmd_done_i} = {3'h4, 1'b1};
		tick(1);
		// Write phase over, so a lagging protect pin sets nothing after the clear
		{cmd_done_i, recal_active_i, is_write_cmd_i} = 3'b000;
		// Byte stands one cycle after the index moves
		tick(2);
		wc = r[7] && id_track_i != r[15:8];
		st[0] = {r[23:22], r[24], r[28] || steps >= 80, 1'b0, r[25], r[27:26]};
		st[1] = {r[6] | r[21], 1'b0, r[5] | r[4], r[3], 1'b0, r[2], r[29] & r[30], r[1] | r[18]};
		st[2] = {1'b0, r[19] ? r[20] : r[0], r[4], wc, 2'b00, wc && id_track_i == 8'hff, r[1]};
		st[3] = {1'b0, r[29], 1'b1, c <= steps, 1'b1, r[25], r[27:26]};
		for (int k = 0; k < 4; k++) begin
			sel_q.push_back(0);
			exp_q.push_back(st[k]);
			data_rd_i = 1'b1;
			tick(1);
			data_rd_i = 1'b0;
			tick(1);
		end
		wp = 1'b0;
		// Let the synchronised protect pin settle before the next command
		tick(3);
	endtask
	task automatic close_out();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		{rstn_i, dor_wr_i, dsr_wr_i, data_rd_i, cmd_done_i, look, load, wp, wdata_i, cyl, ev} = '0;
		{device_config_reg_i, id_track_i, internal_track_i, termination_code_i, drive_sel_i} = '0;
		{drive_select_outputs_i, result_count_i, is_write_cmd_i, is_read_deleted_i} = '0;
		{positioning_done_i, recal_step_i, recal_active_i, rel_seek_outward_i} = '0;
		{no_tc_at_end_i, head_addr_i, density_high_i, side_select_output_i, id_mark_seen_i} = '0;
		num_errors = 0;
		samples_checked = 0;
		seed = 32'h80fb;
		hard_reset();
		for (int i = 0; i < 16; i++) begin
			device_config_reg_i = {4'h0, i[1:0], 2'h0};
			density_high_i = i[2];
			wr(1'b1, {4'h0, i[3], 3'h4});
			tick(1);
			note(1, {6'h0, i[1:0] == 2'h1 || i[3], i[2] ^ (i[1:0] == 2'h1 || i[1:0] == 2'h2)});
		end
		wr(1'b0, 8'h80);
		tick(2);
		note(3, 8'h00);
		wr(1'b1, 8'h08);
		wr(1'b0, 8'h00);
		tick(2);
		note(3, 8'h03);
		note(2, 8'h08);
		wr(1'b1, 8'h0c);
		tick(1);
		// Termination codes cycle so every code is read back
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			run_cmd({seed[31:24], i[1:0], seed[21:0]}, seed[31] ? 8'h00 : 8'h05, 0);
		end
		run_cmd(32'h0, 8'h5a, 80);
		run_cmd(32'h0, 8'h4f, 79);
		hard_reset();
		wr(1'b1, 8'h04);
		tick(1);
		run_cmd(xs(seed), 8'h00, 0);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		num_errors++;
		close_out();
	end
endmodule
